// ---- hw/pmc_device.sv ----
// converter end: command decode, setpoint and startup control
// Operation
// - power-up default 0: run with input power
// - default 1: wait for pin and command
// - command-response bit gates the enable bit
// - pin-response 0: pin ignored
// - pin-response 1: pin must be asserted
// - rise time: exponent -4, top mantissa bits zero
// - eight rise times, exponent 11100, fixed codes
// - divider word: exponent -9 above 11-bit mantissa
// - divider default 256, at most 512
// - trim and margin move the reference value
// - offset is 2^-10 value added to setpoint
// - host keeps offset top two bits equal
// - offset beyond 25 percent: zero, alert, flags
// - setpoint steps 0.4 percent within 25 percent; vref_o steps one code of 614, about 0.16 percent
// - margins exponent -10, bit 15 zero, plus trim
// - host keeps margin plus trim within range; pmc_host checks only margin bit 15
// - store command saves margins and warning limit
// - run control bits 5:2 select margin mode
// - warning limit exponent -1, five low bits
// - later revisions hold warning limit at 8.5A
// - temperature status reports fault and warning
// - run control bit 7 is output enable
// - setup bits: 4 power-up, 3 command, 2 pin
// - every transaction carries a checked PEC byte
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module pmc_device
  import pmc_pkg::*;
#(
  parameter bit FIXED_OC = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // link to the host
  pmc_link_if.dev link,
  // converter side
  input wire logic power_present_i,
  input wire logic on_off_pin_i,
  input wire logic ot_fault_i,
  input wire logic ot_warn_i,
  output logic run_o,
  output logic [15:0] vref_o,
  output pmc_margin_e margin_o,
  output logic fault_act_o,
  output logic [2:0] rise_sel_o,
  output logic [10:0] divider_o,
  output logic [4:0] oc_warn_o,
  // non-volatile store port
  output logic nvm_store_o,
  output logic [15:0] nvm_upper_o,
  output logic [15:0] nvm_lower_o,
  output logic [4:0] nvm_oc_o
);
`include "pmc_defines.svh"

  logic [7:0] run_ctrl_q, run_ctrl_d;
  logic [4:0] sw_q, sw_d;
  logic [2:0] rise_q, rise_d;
  logic [10:0] div_q, div_d;
  logic [15:0] ofs_q, ofs_d;
  logic [15:0] upper_q, upper_d;
  logic [15:0] lower_q, lower_d;
  logic [4:0] oc_q, oc_d;
  logic [1:0] temp_q, temp_d;
  logic [2:0] cml_q, cml_d;
  logic alert_q, alert_d;
  logic store_q, store_d;
  logic run_q, run_d;
  logic [15:0] vref_q, vref_d;
  pmc_margin_e margin_q, margin_d;
  logic fact_q, fact_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_nak_q, rsp_nak_d;
  logic [15:0] rsp_data_q, rsp_data_d;
  logic [7:0] rsp_pec_q, rsp_pec_d;
  logic pin_s1_q, pin_s2_q, pin_s3_q, pin_q;

  // signed value times divider ratio, result in reference units
  function automatic logic signed [28:0] pmc_ref_of(
      input logic signed [16:0] v, input logic [10:0] s);
    logic signed [28:0] p;
    p = v * $signed({1'b0, s});
    return p >>> `PMC_DIV_SHIFT;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // on/off pin synchroniser
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      pin_s1_q <= on_off_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command decode and converter control
  always_comb begin
    logic [15:0] w;
    logic signed [28:0] dref;
    logic signed [28:0] lim;
    logic pin_on;
    logic cmd_on;
    w = link.req_data;
    pin_on = 1'b0;
    cmd_on = 1'b0;
    dref = '0;
    lim = 29'($signed({1'b0, `PMC_TRIM_LIMIT}));
    run_ctrl_d = run_ctrl_q;
    sw_d = sw_q;
    rise_d = rise_q;
    div_d = div_q;
    ofs_d = ofs_q;
    upper_d = upper_q;
    lower_d = lower_q;
    oc_d = oc_q;
    temp_d = temp_q;
    cml_d = cml_q;
    store_d = 1'b0;
    rsp_valid_d = 1'b0;
    rsp_nak_d = 1'b0;
    rsp_data_d = rsp_data_q;
    if (link.req_valid) begin
      rsp_valid_d = 1'b1;
      rsp_data_d = w;
      if (pmc_pec3(link.req_code, w) != link.req_pec) begin
        cml_d[`PMC_CML_PEC] = 1'b1;
        rsp_nak_d = 1'b1;
      end else if (link.req_write) begin
        case (link.req_code)
          `PMC_CMD_RUN_CTRL: run_ctrl_d = w[7:0];
          `PMC_CMD_SWITCH_SETUP: sw_d = {w[4:1], 1'b1};
          `PMC_CMD_CLEAR_STATUS: begin
            cml_d = '0;
            temp_d = '0;
          end
          `PMC_CMD_STORE_ALL: store_d = 1'b1;
          `PMC_CMD_OFFSET: begin
            dref = pmc_ref_of(17'($signed(w)), div_q);
            if (w[15] != w[14] || dref > lim || dref < -lim) begin
              ofs_d = '0;
              cml_d[`PMC_CML_BAD_DATA] = 1'b1;
            end else begin
              ofs_d = w;
            end
          end
          `PMC_CMD_UPPER_MARGIN, `PMC_CMD_LOWER_MARGIN: begin
            if (w[15]) begin
              cml_d[`PMC_CML_BAD_DATA] = 1'b1;
            end else if (link.req_code == `PMC_CMD_UPPER_MARGIN) begin
              upper_d = w;
            end else begin
              lower_d = w;
            end
          end
          `PMC_CMD_DIVIDER: begin
            if (w[15:11] != `PMC_EXP_DIV || w[10:0] > `PMC_DIV_MAX) begin
              cml_d[`PMC_CML_BAD_DATA] = 1'b1;
            end else begin
              div_d = w[10:0];
            end
          end
          `PMC_CMD_OC_WARN: begin
            if (w[15:11] != `PMC_EXP_OC || w[10:5] != 6'h00) begin
              cml_d[`PMC_CML_BAD_DATA] = 1'b1;
            end else if (!FIXED_OC) begin
              oc_d = w[4:0];
            end
          end
          `PMC_CMD_SOFT_START: begin
            cml_d[`PMC_CML_BAD_DATA] = 1'b1;
            if (w[15:11] == `PMC_EXP_RISE && w[10:9] == 2'h0) begin
              for (int i = 0; i < 8; i++) begin
                if (w[10:0] == PMC_RISE_TBL[i]) begin
                  rise_d = 3'(i);
                  cml_d[`PMC_CML_BAD_DATA] = cml_q[`PMC_CML_BAD_DATA];
                end
              end
            end
          end
          default: begin
            cml_d[`PMC_CML_BAD_CMD] = 1'b1;
            rsp_nak_d = 1'b1;
          end
        endcase
      end else begin
        case (link.req_code)
          `PMC_CMD_RUN_CTRL: rsp_data_d = {8'h00, run_ctrl_q};
          `PMC_CMD_SWITCH_SETUP: rsp_data_d = {11'h000, sw_q};
          `PMC_CMD_OFFSET: rsp_data_d = ofs_q;
          `PMC_CMD_UPPER_MARGIN: rsp_data_d = upper_q;
          `PMC_CMD_LOWER_MARGIN: rsp_data_d = lower_q;
          `PMC_CMD_DIVIDER: rsp_data_d = {`PMC_EXP_DIV, div_q};
          `PMC_CMD_OC_WARN: rsp_data_d = {`PMC_EXP_OC, 6'h00, oc_q};
          `PMC_CMD_SOFT_START: rsp_data_d = {`PMC_EXP_RISE,
                                             PMC_RISE_TBL[rise_q]};
          `PMC_CMD_SUMMARY: rsp_data_d = {14'h0000, |cml_q, 1'b0};
          `PMC_CMD_TEMP_STATUS: rsp_data_d = {8'h00, temp_q, 6'h00};
          `PMC_CMD_COMM_STATUS: rsp_data_d = {8'h00, cml_q, 5'h00};
          default: begin
            rsp_data_d = '0;
            cml_d[`PMC_CML_BAD_CMD] = 1'b1;
            rsp_nak_d = 1'b1;
          end
        endcase
      end
    end
    // temperature events set after a clear in the same cycle
    temp_d = temp_d | {ot_fault_i, ot_warn_i};
    alert_d = |cml_d;
    rsp_pec_d = pmc_pec3(link.req_code, rsp_data_d);

    margin_d = PMC_MARGIN_OFF;
    fact_d = 1'b0;
    case (run_ctrl_q[5:2])
      4'h5, 4'h6: margin_d = PMC_MARGIN_LOW;
      4'h9, 4'hA: margin_d = PMC_MARGIN_HIGH;
      default: margin_d = PMC_MARGIN_OFF;
    endcase
    if (margin_d != PMC_MARGIN_OFF) begin
      fact_d = run_ctrl_q[3:2] == 2'h2;
    end

    case (margin_q)
      PMC_MARGIN_HIGH: dref = pmc_ref_of(
        17'($signed(upper_q)) + 17'($signed(ofs_q)), div_q);
      PMC_MARGIN_LOW: dref = pmc_ref_of(
        17'($signed(lower_q)) + 17'($signed(ofs_q)), div_q);
      default: dref = 29'($signed({1'b0, `PMC_VREF_NOM})) +
        pmc_ref_of(17'($signed(ofs_q)), div_q);
    endcase
    vref_d = dref[15:0];

    pin_on = !sw_q[`PMC_SW_PINRESP_BIT] ||
             (pin_q == sw_q[`PMC_SW_POL_BIT]);
    cmd_on = !sw_q[`PMC_SW_CMDRESP_BIT] ||
             run_ctrl_q[`PMC_RUN_EN_BIT];
    if (!sw_q[`PMC_SW_PWRUP_BIT]) begin
      run_d = power_present_i;
    end else begin
      run_d = power_present_i && pin_on && cmd_on;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      run_ctrl_q <= `PMC_RUN_RESET;
      sw_q <= `PMC_SW_RESET;
      rise_q <= `PMC_RISE_RESET;
      div_q <= `PMC_DIV_RESET;
      ofs_q <= `PMC_OFFSET_RESET;
      upper_q <= `PMC_MARGIN_RESET;
      lower_q <= `PMC_MARGIN_RESET;
      oc_q <= FIXED_OC ? `PMC_OC_FIXED : `PMC_OC_RESET;
      temp_q <= '0;
      cml_q <= '0;
      alert_q <= 1'b0;
      store_q <= 1'b0;
      run_q <= 1'b0;
      vref_q <= `PMC_VREF_NOM;
      margin_q <= PMC_MARGIN_OFF;
      fact_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_nak_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_pec_q <= '0;
    end else begin
      run_ctrl_q <= run_ctrl_d;
      sw_q <= sw_d;
      rise_q <= rise_d;
      div_q <= div_d;
      ofs_q <= ofs_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      oc_q <= oc_d;
      temp_q <= temp_d;
      cml_q <= cml_d;
      alert_q <= alert_d;
      store_q <= store_d;
      run_q <= run_d;
      vref_q <= vref_d;
      margin_q <= margin_d;
      fact_q <= fact_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_nak_q <= rsp_nak_d;
      rsp_data_q <= rsp_data_d;
      rsp_pec_q <= rsp_pec_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_nak = rsp_nak_q;
  assign link.rsp_data = rsp_data_q;
  assign link.rsp_pec = rsp_pec_q;
  assign link.alert = alert_q;
  assign run_o = run_q;
  assign vref_o = vref_q;
  assign margin_o = margin_q;
  assign fault_act_o = fact_q;
  assign rise_sel_o = rise_q;
  assign divider_o = div_q;
  assign oc_warn_o = oc_q;
  assign nvm_store_o = store_q;
  assign nvm_upper_o = upper_q;
  assign nvm_lower_o = lower_q;
  assign nvm_oc_o = oc_q;
endmodule

// ---- hw/pmc_defines.svh ----
// command codes, field positions, reset values and limits
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// command codes on the management link
`define PMC_CMD_RUN_CTRL 8'h01
`define PMC_CMD_SWITCH_SETUP 8'h02
`define PMC_CMD_CLEAR_STATUS 8'h03
`define PMC_CMD_STORE_ALL 8'h11
`define PMC_CMD_OFFSET 8'h22
`define PMC_CMD_UPPER_MARGIN 8'h25
`define PMC_CMD_LOWER_MARGIN 8'h26
`define PMC_CMD_DIVIDER 8'h29
`define PMC_CMD_OC_WARN 8'h4A
`define PMC_CMD_SOFT_START 8'h61
`define PMC_CMD_SUMMARY 8'h78
`define PMC_CMD_TEMP_STATUS 8'h7D
`define PMC_CMD_COMM_STATUS 8'h7E
// power switch setup fields
`define PMC_SW_PWRUP_BIT 4
`define PMC_SW_CMDRESP_BIT 3
`define PMC_SW_PINRESP_BIT 2
`define PMC_SW_POL_BIT 1
`define PMC_SW_RESET 5'h17
`define PMC_RUN_EN_BIT 7
`define PMC_RUN_RESET 8'h00
// fixed exponents
`define PMC_EXP_RISE 5'h1C
`define PMC_EXP_DIV 5'h17
`define PMC_EXP_OC 5'h1F
// divider ratio mantissa, 512 means ratio one
`define PMC_DIV_RESET 11'h100
`define PMC_DIV_MAX 11'h200
`define PMC_DIV_SHIFT 9
// nominal reference 600 mV in 2^-10 V, quarter of it
`define PMC_VREF_NOM 16'h0266
`define PMC_TRIM_LIMIT 16'h0099
`define PMC_OFFSET_RESET 16'h0000
`define PMC_MARGIN_RESET 16'h0000
`define PMC_OC_FIXED 5'h11
`define PMC_OC_RESET 5'h11
`define PMC_RISE_RESET 3'h0
// soft start mantissa codes
`define PMC_RISE_M0 11'h00A
`define PMC_RISE_M1 11'h00E
`define PMC_RISE_M2 11'h013
`define PMC_RISE_M3 11'h01D
`define PMC_RISE_M4 11'h02B
`define PMC_RISE_M5 11'h043
`define PMC_RISE_M6 11'h060
`define PMC_RISE_M7 11'h090
// status bit positions
`define PMC_SUM_CML_BIT 1
`define PMC_CML_BAD_CMD 2
`define PMC_CML_BAD_DATA 1
`define PMC_CML_PEC 0
`define PMC_CRC_POLY 8'h07
// host register offsets
`define PMC_H_CODE 3'h0
`define PMC_H_DATA 3'h1
`define PMC_H_GO 3'h2
`define PMC_H_STATUS 3'h3
`define PMC_H_RDATA 3'h4
`endif

// ---- hw/pmc_pkg.sv ----
// types and helpers shared by both ends of the management link
package pmc_pkg;
`include "pmc_defines.svh"
  typedef enum logic [1:0] {
    PMC_MARGIN_OFF,
    PMC_MARGIN_LOW,
    PMC_MARGIN_HIGH
  } pmc_margin_e;

  typedef enum logic {PMC_H_IDLE, PMC_H_WAIT} pmc_host_e;

  localparam logic [10:0] PMC_RISE_TBL [8] = '{`PMC_RISE_M0,
    `PMC_RISE_M1, `PMC_RISE_M2, `PMC_RISE_M3, `PMC_RISE_M4,
    `PMC_RISE_M5, `PMC_RISE_M6, `PMC_RISE_M7};

  function automatic logic [7:0] pmc_crc8(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `PMC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // check byte over code, low data byte, high data byte
  function automatic logic [7:0] pmc_pec3(input logic [7:0] code,
                                          input logic [15:0] data);
    return pmc_crc8(pmc_crc8(pmc_crc8(8'h00, code), data[7:0]),
                    data[15:8]);
  endfunction
endpackage

// ---- hw/pmc_link_if.sv ----
// management link between host controller and converter end
`timescale 1ns/100ps
interface pmc_link_if (
  input logic clk
);
  logic req_valid;
  logic req_write;
  logic [7:0] req_code;
  logic [15:0] req_data;
  logic [7:0] req_pec;
  logic rsp_valid;
  logic rsp_nak;
  logic [15:0] rsp_data;
  logic [7:0] rsp_pec;
  logic alert;

  modport dev (
    input req_valid, req_write, req_code, req_data, req_pec,
    output rsp_valid, rsp_nak, rsp_data, rsp_pec, alert
  );
  modport host (
    output req_valid, req_write, req_code, req_data, req_pec,
    input rsp_valid, rsp_nak, rsp_data, rsp_pec, alert
  );
endinterface

// ---- hw/pmc_host.sv ----
// host controller end: software port to link transactions
`timescale 1ns/100ps
module pmc_host
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // software register port
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // link to the converter
  pmc_link_if.host link
);
`include "pmc_defines.svh"

  pmc_host_e st_q, st_d;
  logic [7:0] code_q, code_d;
  logic [15:0] data_q, data_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] rdata_q, rdata_d;
  logic req_q, req_d;
  logic wr_q, wr_d;
  logic [7:0] pec_q, pec_d;
  logic nak_q, nak_d;
  logic pec_err_q, pec_err_d;
  logic refused_q, refused_d;

  //////////////////////////////////////////////////////////////////////
  // transaction sequencing
  always_comb begin
    logic bad;
    bad = 1'b0;
    st_d = st_q;
    code_d = code_q;
    data_d = data_q;
    rx_d = rx_q;
    req_d = 1'b0;
    wr_d = wr_q;
    pec_d = pec_q;
    nak_d = nak_q;
    pec_err_d = pec_err_q;
    refused_d = refused_q;
    rdata_d = '0;
    if (wr_i && st_q == PMC_H_IDLE) begin
      case (addr_i)
        `PMC_H_CODE: code_d = wdata_i[7:0];
        `PMC_H_DATA: data_d = wdata_i;
        default: code_d = code_q;
      endcase
    end
    case (st_q)
      PMC_H_IDLE: begin
        if (wr_i && addr_i == `PMC_H_GO && |wdata_i[1:0]) begin
          // offset top two bits must match
          if (wdata_i[0] && code_q == `PMC_CMD_OFFSET) begin
            bad = data_q[15] != data_q[14];
          end
          // margin kept positive: only bit 15 is checked
          if (wdata_i[0] && (code_q == `PMC_CMD_UPPER_MARGIN ||
                             code_q == `PMC_CMD_LOWER_MARGIN)) begin
            bad = data_q[15];
          end
          refused_d = bad;
          if (!bad) begin
            req_d = 1'b1;
            wr_d = wdata_i[0];
            pec_d = pmc_pec3(code_q, wdata_i[0] ? data_q : 16'h0000);
            st_d = PMC_H_WAIT;
          end
        end
      end
      PMC_H_WAIT: begin
        if (link.rsp_valid) begin
          rx_d = link.rsp_data;
          nak_d = link.rsp_nak;
          pec_err_d = pmc_pec3(code_q, link.rsp_data) != link.rsp_pec;
          st_d = PMC_H_IDLE;
        end
      end
      default: st_d = PMC_H_IDLE;
    endcase
    if (rd_i) begin
      case (addr_i)
        `PMC_H_CODE: rdata_d = {8'h00, code_q};
        `PMC_H_DATA: rdata_d = data_q;
        `PMC_H_STATUS: rdata_d = {11'h000, refused_q, link.alert,
                                  pec_err_q, nak_q, st_q == PMC_H_WAIT};
        `PMC_H_RDATA: rdata_d = rx_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_q <= PMC_H_IDLE;
      code_q <= '0;
      data_q <= '0;
      rx_q <= '0;
      rdata_q <= '0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      pec_q <= '0;
      nak_q <= 1'b0;
      pec_err_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      data_q <= data_d;
      rx_q <= rx_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      wr_q <= wr_d;
      pec_q <= pec_d;
      nak_q <= nak_d;
      pec_err_q <= pec_err_d;
      refused_q <= refused_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = rdata_q;
  assign link.req_valid = req_q;
  assign link.req_write = wr_q;
  assign link.req_code = code_q;
  assign link.req_data = wr_q ? data_q : 16'h0000;
  assign link.req_pec = pec_q;
endmodule

// ---- tb/pmc_link_sva.sv ----
// assertions on the management link between host and converter
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmc_link_sva
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst_i,
  // request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_data,
  input wire logic [7:0] req_pec,
  // answer side
  input wire logic rsp_valid,
  input wire logic rsp_nak,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] rsp_pec,
  input wire logic alert
);
  function automatic logic [7:0] step(input logic [7:0] c,
                                      input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] pec(input logic [7:0] k,
                                     input logic [15:0] d);
    return step(step(step(8'h00, k), d[7:0]), d[15:8]);
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////
  chk_rsp_next: assert property (req_valid |=> rsp_valid)
    else $error("no answer after request");
  chk_rsp_idle: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  chk_host_pec: assert property (
    req_valid |-> req_pec == pec(req_code, req_data))
    else $error("request check byte wrong");
  chk_dev_pec: assert property (
    rsp_valid |-> rsp_pec == pec($past(req_code), rsp_data))
    else $error("answer check byte wrong");
  chk_write_echo: assert property (
    req_valid && req_write |=> rsp_data == $past(req_data))
    else $error("write answer lacks echo");
  chk_good_no_nak: assert property (
    req_valid && req_code == `PMC_CMD_OFFSET &&
    req_pec == pec(req_code, req_data) |=> !rsp_nak)
    else $error("good request refused");
  chk_read_zero: assert property (
    req_valid && !req_write |-> req_data == 16'h0000)
    else $error("read carries data");
  chk_req_single: assert property (req_valid |=> !req_valid)
    else $error("request held too long");
  chk_alert_cause: assert property ($rose(alert) |-> rsp_valid)
    else $error("alert rose without answer");
  chk_alert_clear: assert property (
    rsp_valid && !rsp_nak && $past(req_write) &&
    $past(req_code) == `PMC_CMD_CLEAR_STATUS |-> ##[0:2] !alert)
    else $error("alert kept after clear");

  cov_offset: cover property (req_valid && req_code == `PMC_CMD_OFFSET);
  cov_alert: cover property ($rose(alert));
  cov_read: cover property (req_valid && !req_write);
endmodule

// ---- tb/pmbus_output_control_tb.sv ----
// bench joining host and converter ends over the link
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmbus_output_control_tb
  import pmc_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pin = 1'b0;
  logic ot_fault = 1'b0;
  logic ot_warn = 1'b0;
  logic pwr = 1'b1;
  logic [15:0] rdata_o, vref_o, nvm_upper_o, nvm_lower_o, st, v;
  logic run_o, fault_act_o, nvm_store_o;
  pmc_margin_e margin_o;
  logic [2:0] rise_sel_o;
  logic [10:0] divider_o;
  logic [4:0] oc_warn_o, nvm_oc_o;
  int failures = 0;
  int check_count = 0;
  int stores = 0;

  pmc_link_if lnk (.clk(core_clk));
  pmc_host i_pmc_host (.core_clk_i(core_clk), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .link(lnk));
  pmc_device #(.FIXED_OC(1'b1)) i_pmc_device (.core_clk_i(core_clk),
    .srst_i(srst_i), .link(lnk), .power_present_i(pwr),
    .on_off_pin_i(pin), .ot_fault_i(ot_fault), .ot_warn_i(ot_warn),
    .run_o(run_o), .vref_o(vref_o), .margin_o(margin_o),
    .fault_act_o(fault_act_o), .rise_sel_o(rise_sel_o),
    .divider_o(divider_o), .oc_warn_o(oc_warn_o),
    .nvm_store_o(nvm_store_o), .nvm_upper_o(nvm_upper_o),
    .nvm_lower_o(nvm_lower_o), .nvm_oc_o(nvm_oc_o));
  pmc_link_sva i_pmc_link_sva (.clk(lnk.clk), .srst_i(srst_i),
    .req_valid(lnk.req_valid), .req_write(lnk.req_write),
    .req_code(lnk.req_code), .req_data(lnk.req_data),
    .req_pec(lnk.req_pec), .rsp_valid(lnk.rsp_valid),
    .rsp_nak(lnk.rsp_nak), .rsp_data(lnk.rsp_data),
    .rsp_pec(lnk.rsp_pec), .alert(lnk.alert));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (nvm_store_o === 1'b1) begin
      stores++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk);
    rd_i <= 1'b0;
    @(negedge core_clk);
    d = rdata_o;
  endtask

  // one link transaction, polled until idle
  task automatic xfer(input logic [7:0] k, input logic [15:0] d,
                      input logic w, input logic [2:0] es = 3'h0);
    int n;
    wr(`PMC_H_CODE, {8'h00, k});
    wr(`PMC_H_DATA, d);
    wr(`PMC_H_GO, w ? 16'h0001 : 16'h0002);
    n = 0;
    st = 16'h0001;
    while (st[0] !== 1'b0 && n < 20) begin
      rd(`PMC_H_STATUS, st);
      n++;
    end
    chk("status", {13'h0000, es}, {13'h0000, st[2:0]});
  endtask

  task automatic get(input logic [7:0] k);
    xfer(k, 16'h0000, 1'b0);
    rd(`PMC_H_RDATA, v);
  endtask

  task automatic bad_clear();
    chk("alert", 16'h0008, st & 16'h0008);
    xfer(`PMC_CMD_CLEAR_STATUS, 16'h0000, 1'b1);
    rd(`PMC_H_STATUS, st);
    chk("alert", 16'h0000, st & 16'h0008);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("run", 16'h0000, 16'(run_o));
    chk("vref", `PMC_VREF_NOM, vref_o);
    chk("div", 16'h0100, 16'(divider_o));
    chk("oc", 16'h0011, 16'(oc_warn_o));
    chk("rise", 16'h0000, 16'(rise_sel_o));
    get(`PMC_CMD_SWITCH_SETUP);
    chk("setup", 16'h0017, {8'h00, v[7:0]});
  endtask

  task automatic t_onoff();
    xfer(`PMC_CMD_SWITCH_SETUP, 16'h0002, 1'b1);
    chk("run", 16'h0001, 16'(run_o));
    @(posedge core_clk);
    pwr <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("run", 16'h0000, 16'(run_o));
    @(posedge core_clk);
    pwr <= 1'b1;
    xfer(`PMC_CMD_SWITCH_SETUP, 16'h001A, 1'b1);
    chk("run", 16'h0000, 16'(run_o));
    xfer(`PMC_CMD_RUN_CTRL, 16'h0080, 1'b1);
    chk("run", 16'h0001, 16'(run_o));
    xfer(`PMC_CMD_SWITCH_SETUP, 16'h001E, 1'b1);
    chk("run", 16'h0000, 16'(run_o));
    @(posedge core_clk);
    pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk("run", 16'h0001, 16'(run_o));
    xfer(`PMC_CMD_RUN_CTRL, 16'h0000, 1'b1);
    chk("run", 16'h0000, 16'(run_o));
    xfer(`PMC_CMD_SWITCH_SETUP, 16'h0016, 1'b1);
    chk("run", 16'h0001, 16'(run_o));
  endtask

  task automatic t_rise_div();
    for (int i = 0; i < 8; i++) begin
      xfer(`PMC_CMD_SOFT_START, {`PMC_EXP_RISE, PMC_RISE_TBL[i]}, 1'b1);
      chk("rise", 16'(i), 16'(rise_sel_o));
    end
    xfer(`PMC_CMD_SOFT_START, {5'h1D, PMC_RISE_TBL[0]}, 1'b1);
    chk("rise", 16'h0007, 16'(rise_sel_o));
    bad_clear();
    xfer(`PMC_CMD_SOFT_START, {`PMC_EXP_RISE, 11'h00B}, 1'b1);
    chk("rise", 16'h0007, 16'(rise_sel_o));
    bad_clear();
    xfer(`PMC_CMD_DIVIDER, {`PMC_EXP_DIV, 11'h200}, 1'b1);
    chk("div", 16'h0200, 16'(divider_o));
    xfer(`PMC_CMD_DIVIDER, {`PMC_EXP_DIV, 11'h201}, 1'b1);
    chk("div", 16'h0200, 16'(divider_o));
    bad_clear();
  endtask

  task automatic t_trim();
    xfer(`PMC_CMD_OFFSET, 16'h0099, 1'b1);
    chk("vref", 16'h02FF, vref_o);
    xfer(`PMC_CMD_OFFSET, 16'hFF67, 1'b1);
    chk("vref", 16'h01CD, vref_o);
    xfer(`PMC_CMD_OFFSET, 16'h009A, 1'b1);
    chk("vref", `PMC_VREF_NOM, vref_o);
    get(`PMC_CMD_COMM_STATUS);
    chk("comm", 16'h0040, v & 16'h00E0);
    get(`PMC_CMD_SUMMARY);
    chk("summary", 16'h0002, v & 16'h0002);
    bad_clear();
    xfer(`PMC_CMD_OFFSET, 16'h8000, 1'b1);
    chk("refused", 16'h0010, st & 16'h0010);
    chk("vref", `PMC_VREF_NOM, vref_o);
  endtask

  task automatic t_margin();
    logic [7:0] op [5] = '{8'h0C, 8'h14, 8'h18, 8'h24, 8'h28};
    logic [1:0] m [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [15:0] vr [5] = '{16'h0266, 16'h0200, 16'h0200, 16'h02CC,
                            16'h02CC};
    xfer(`PMC_CMD_UPPER_MARGIN, 16'h02CC, 1'b1);
    xfer(`PMC_CMD_LOWER_MARGIN, 16'h0200, 1'b1);
    for (int i = 0; i < 5; i++) begin
      xfer(`PMC_CMD_RUN_CTRL, {8'h00, op[i]}, 1'b1);
      chk("margin", 16'(m[i]), 16'(margin_o));
      chk("fault", 16'(i == 2 || i == 4), 16'(fault_act_o));
      chk("vref", vr[i], vref_o);
    end
    xfer(`PMC_CMD_OFFSET, 16'h0010, 1'b1);
    chk("vref", 16'h02DC, vref_o);
    xfer(`PMC_CMD_UPPER_MARGIN, 16'h8000, 1'b1);
    get(`PMC_CMD_UPPER_MARGIN);
    chk("upper", 16'h02CC, v);
  endtask

  task automatic t_store_temp();
    xfer(`PMC_CMD_OC_WARN, {`PMC_EXP_OC, 11'h005}, 1'b1);
    chk("oc", 16'h0011, 16'(oc_warn_o));
    xfer(`PMC_CMD_OC_WARN, {`PMC_EXP_OC, 11'h020}, 1'b1);
    bad_clear();
    xfer(8'h55, 16'h0000, 1'b0, 3'h2);
    bad_clear();
    xfer(`PMC_CMD_STORE_ALL, 16'h0000, 1'b1);
    chk("stores", 16'h0001, 16'(stores));
    chk("nvm_up", 16'h02CC, nvm_upper_o);
    chk("nvm_lo", 16'h0200, nvm_lower_o);
    chk("nvm_oc", 16'h0011, 16'(nvm_oc_o));
    @(posedge core_clk);
    ot_warn <= 1'b1;
    @(posedge core_clk);
    ot_warn <= 1'b0;
    get(`PMC_CMD_TEMP_STATUS);
    chk("temp", 16'h0040, v & 16'h00C0);
    @(posedge core_clk);
    ot_fault <= 1'b1;
    @(posedge core_clk);
    ot_fault <= 1'b0;
    get(`PMC_CMD_TEMP_STATUS);
    chk("temp", 16'h00C0, v & 16'h00C0);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    srst_i <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_onoff();
    t_rise_div();
    t_trim();
    t_margin();
    t_store_temp();
    finish_test();
  end
endmodule
